// >>> psq_cfg_if.sv
// Configuration and status carrier between serial port and sequencer
`timescale 1ns/100ps
`default_nettype none
interface psq_cfg_if;
  import psq_pkg::*;
  psq_mode_type mode;
  logic [11:0] trig_delay;
  logic spi_active;
  logic busy;
  logic fault;
  modport spi (output mode, trig_delay, spi_active, input busy, fault);
  modport core (input mode, trig_delay, spi_active, output busy, fault);
endinterface
`default_nettype wire

// >>> psq_host_model.sv
// Host board model: serial master that configures the sequencer
`timescale 1ns/100ps
`default_nettype none
module psq_host_model (
  input wire logic clock_i,
  input wire logic link_permit_i,
  input wire logic miso_i,
  input wire logic miso_oe_n_i,
  output logic sclk_o,
  output logic mosi_o,
  output logic ss_n_o
);
  logic last_bit;
  logic miso_wire;
  int half_cyc;

  // A released line holds no value, so show the inverse of the last bit
  assign miso_wire = miso_oe_n_i ? ~last_bit : miso_i;

  // Remember the last driven level of the data line
  always @(posedge clock_i) begin
    if (!miso_oe_n_i) begin
      last_bit <= miso_i;
    end
  end

  initial begin
    last_bit = 1'b0;
    half_cyc = 10;
    sclk_o = 1'b0;
    mosi_o = 1'b0;
    ss_n_o = 1'b1;
  end

  task automatic wait_cyc(input int n);
    repeat (n) @(negedge clock_i);
  endtask

  // One frame, MSB first; 10 MHz serial clock keeps within the allowed rate
  task automatic xfer(input logic [15:0] word, input int nbits,
                      output logic [15:0] rdata);
    int i;
    rdata = 16'h0000;
    while (link_permit_i !== 1'b1) begin
      @(negedge clock_i);
    end
    ss_n_o = 1'b0;
    wait_cyc(20);
    for (i = 0; i < nbits; i++) begin
      mosi_o = word[15 - i];
      wait_cyc(half_cyc);
      sclk_o = 1'b1;
      rdata = {rdata[14:0], miso_wire};
      wait_cyc(half_cyc);
      sclk_o = 1'b0;
    end
    wait_cyc(half_cyc);
    ss_n_o = 1'b1;
    mosi_o = ~mosi_o;
    wait_cyc(20);
  endtask
endmodule // psq_host_model
`default_nettype wire

// >>> psq_pkg.sv
// Package of constants, types and helpers for the plate scan sequencer
package psq_pkg;
  typedef enum logic [1:0] {
    PSQ_STD_SMALL, PSQ_STD_LARGE, PSQ_HR_SMALL, PSQ_HR_LARGE
  } psq_mode_type;
  typedef enum logic [1:0] {ST_IDLE, ST_WAIT, ST_ACQ} psq_state_type;

  localparam int CLK_PERIOD_NS = 5;
  localparam int STD_PERIOD_NS = 2800000;
  localparam int HR_PERIOD_NS = 5000000;
  localparam int STD_PERIOD_CYC = STD_PERIOD_NS / CLK_PERIOD_NS;
  localparam int HR_PERIOD_CYC = HR_PERIOD_NS / CLK_PERIOD_NS;
  localparam logic [10:0] PIX_STD = 11'h384;
  localparam logic [10:0] PIX_HR = 11'h5a0;
  localparam logic [11:0] LINES_STD_SMALL = 12'h514;
  localparam logic [11:0] LINES_STD_LARGE = 12'h640;
  localparam logic [11:0] LINES_HR_SMALL = 12'h820;
  localparam logic [11:0] LINES_HR_LARGE = 12'ha28;
  localparam int BUS_HALF_NS = 500;
  localparam int BUS_LEAD_NS = 1000;
  localparam logic [7:0] BUS_HALF_CYC = 8'(BUS_HALF_NS / CLK_PERIOD_NS);
  localparam logic [7:0] SLOT_CYC = 8'(2 * BUS_HALF_NS / CLK_PERIOD_NS);
  localparam logic [19:0] BUS_LEAD_CYC = 20'(BUS_LEAD_NS / CLK_PERIOD_NS);
  localparam logic [11:0] DELAY_MIN = 12'h064;
  localparam logic [11:0] DELAY_MAX = 12'hfa0;
  localparam logic [11:0] DELAY_RESET = 12'h064;
  localparam psq_mode_type MODE_RESET = PSQ_STD_SMALL;
  localparam int SPI_BITS = 16;
  localparam logic [2:0] ADDR_MODE = 3'h0;
  localparam logic [2:0] ADDR_DELAY = 3'h1;
  localparam logic [2:0] ADDR_STATUS = 3'h2;

  function automatic logic psq_is_hr(input psq_mode_type m);
    return (m == PSQ_HR_SMALL) || (m == PSQ_HR_LARGE);
  endfunction

  function automatic logic [10:0] psq_pix_count(input psq_mode_type m);
    return psq_is_hr(m) ? PIX_HR : PIX_STD;
  endfunction

  function automatic logic [11:0] psq_line_count(input psq_mode_type m);
    case (m)
      PSQ_STD_SMALL: return LINES_STD_SMALL;
      PSQ_STD_LARGE: return LINES_STD_LARGE;
      PSQ_HR_SMALL: return LINES_HR_SMALL;
      default: return LINES_HR_LARGE;
    endcase
  endfunction
endpackage

// >>> psq_plate_scan_sequencer.sv
// Top level frame sequencer and pixel bus driver of the plate reader
`timescale 1ns/100ps
`default_nettype none
module psq_plate_scan_sequencer #(
  parameter int MIRROR_STD_CYC = psq_pkg::STD_PERIOD_CYC,
  parameter int MIRROR_HR_CYC = psq_pkg::HR_PERIOD_CYC
) (
  input wire logic clock_i,
  input wire logic sys_rst_i,
  input wire logic sequence_trigger_in_i,
  input wire logic spi_sclk_i,
  input wire logic spi_mosi_i,
  input wire logic spi_ss_n_i,
  output logic spi_miso_o,
  output logic spi_miso_oe_n_o,
  input wire logic [15:0] adc_data_i,
  input wire logic overcurrent_i,
  input wire logic temp_sensor_open_i,
  input wire logic temp_abnormal_i,
  input wire logic supply_unstable_i,
  output logic frame_busy_o,
  output logic link_permit_o,
  output logic line_scan_o,
  output logic bus_clk_o,
  output logic bus_line_o,
  output logic [15:0] bus_data_o,
  output logic bias_supply_fault_o,
  output logic mirror_drive_o
);
  import psq_pkg::*;

  psq_cfg_if cfg_if ();

  psq_spi_slave u_spi (
    .clock_i(clock_i),
    .sys_rst_i(sys_rst_i),
    .spi_sclk_i(spi_sclk_i),
    .spi_mosi_i(spi_mosi_i),
    .spi_ss_n_i(spi_ss_n_i),
    .spi_miso_o(spi_miso_o),
    .spi_miso_oe_n_o(spi_miso_oe_n_o),
    .cfg(cfg_if.spi)
  );

  logic [4:0] meta_ff, sync_ff;
  logic trig_sync, fault_ff;
  psq_state_type st_ff, nxt_st;
  logic [19:0] pc_ff, nxt_pc, period_cyc, pix_end;
  logic [11:0] dly_ff, nxt_dly, line_ff, nxt_line, nlines;
  logic [7:0] slot_ff, nxt_slot;
  logic [15:0] data_ff, nxt_data;
  logic clk_ff, nxt_clk, lv_ff, nxt_lv, ls_ff, nxt_ls, mir_ff, nxt_mir;
  logic period_end, in_pix, in_line, last_line;

  // Trigger and fault pins pass two stages; fault is a registered OR of the four fault pins
  always_ff @(posedge clock_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      meta_ff <= 5'h00;
      sync_ff <= 5'h00;
      fault_ff <= 1'b0;
    end else begin
      meta_ff <= {supply_unstable_i, temp_abnormal_i, temp_sensor_open_i,
                  overcurrent_i, sequence_trigger_in_i};
      sync_ff <= meta_ff;
      fault_ff <= |sync_ff[4:1];
    end
  end
  assign trig_sync = sync_ff[0];

  // Mode decides mirror period, pixel and line counts
  assign period_cyc = psq_is_hr(cfg_if.mode) ? 20'(MIRROR_HR_CYC)
                                             : 20'(MIRROR_STD_CYC);
  assign nlines = psq_line_count(cfg_if.mode);
  assign pix_end = BUS_LEAD_CYC
                 + 20'(psq_pix_count(cfg_if.mode)) * 20'(SLOT_CYC);
  // A shorter period after a mode change must still wrap, hence >=
  assign period_end = pc_ff >= period_cyc - 20'h00001;
  assign in_line = pc_ff < pix_end;
  assign in_pix = in_line && pc_ff >= BUS_LEAD_CYC;
  assign last_line = line_ff == nlines - 12'h001;

  // Sequencer and line timing next values
  always_comb begin
    nxt_st = st_ff;
    nxt_dly = dly_ff;
    nxt_line = line_ff;
    nxt_pc = period_end ? 20'h00000 : pc_ff + 20'h00001;
    nxt_mir = pc_ff < (period_cyc >> 1);
    nxt_slot = 8'h00;
    nxt_data = data_ff;
    nxt_clk = 1'b0;
    nxt_lv = 1'b0;
    nxt_ls = 1'b0;
    case (st_ff)
      ST_IDLE: begin
        // Waiting for a frame in flight on the serial port avoids racing
        // a setting change against the start
        if (trig_sync && !cfg_if.spi_active) begin
          nxt_st = ST_WAIT;
          nxt_dly = 12'h000;
        end
      end
      ST_WAIT: begin
        // Delay counts mirror periods; acquisition opens on a sweep start
        if (period_end) begin
          if (dly_ff + 12'h001 >= cfg_if.trig_delay) begin
            nxt_st = ST_ACQ;
            nxt_line = 12'h000;
          end else begin
            nxt_dly = dly_ff + 12'h001;
          end
        end
      end
      ST_ACQ: begin
        // Trigger is not looked at here, so retriggers are dropped
        if (period_end) begin
          if (last_line)
            nxt_st = ST_IDLE;
          else
            nxt_line = line_ff + 12'h001;
        end
        nxt_lv = in_line;
        nxt_ls = in_pix;
        if (in_pix) begin
          nxt_slot = (slot_ff == SLOT_CYC - 8'h01) ? 8'h00
                                                    : slot_ff + 8'h01;
          nxt_clk = slot_ff >= BUS_HALF_CYC;
          if (slot_ff == 8'h00)
            nxt_data = adc_data_i;
        end
      end
      default: nxt_st = ST_IDLE;
    endcase
  end

  // Register sequencer and bus state
  always_ff @(posedge clock_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      st_ff <= ST_IDLE;
      pc_ff <= 20'h00000;
      dly_ff <= 12'h000;
      line_ff <= 12'h000;
      slot_ff <= 8'h00;
      data_ff <= 16'h0000;
      clk_ff <= 1'b0;
      lv_ff <= 1'b0;
      ls_ff <= 1'b0;
      mir_ff <= 1'b0;
    end else begin
      st_ff <= nxt_st;
      pc_ff <= nxt_pc;
      dly_ff <= nxt_dly;
      line_ff <= nxt_line;
      slot_ff <= nxt_slot;
      data_ff <= nxt_data;
      clk_ff <= nxt_clk;
      lv_ff <= nxt_lv;
      ls_ff <= nxt_ls;
      mir_ff <= nxt_mir;
    end
  end

  // Busy covers delay and acquisition; permit is its complement
  assign frame_busy_o = st_ff != ST_IDLE;
  assign link_permit_o = !frame_busy_o;
  assign line_scan_o = ls_ff;
  assign bus_clk_o = clk_ff;
  assign bus_line_o = lv_ff;
  assign bus_data_o = data_ff;
  assign bias_supply_fault_o = fault_ff;
  assign mirror_drive_o = mir_ff;
  assign cfg_if.busy = frame_busy_o;
  assign cfg_if.fault = fault_ff;

  default clocking cb @(posedge clock_i); endclocking
  default disable iff (sys_rst_i);

  a_trig_start: assert property (
    st_ff == ST_IDLE && trig_sync && !cfg_if.spi_active
    |=> frame_busy_o && !link_permit_o)
    else $error("trigger did not start a frame");
  a_busy_cause: assert property (
    $rose(frame_busy_o) |-> $past(trig_sync, 1))
    else $error("busy rose without trigger");
  a_permit_busy: assert property (
    link_permit_o != frame_busy_o)
    else $error("permit and busy disagree");
  a_delay_done: assert property (
    st_ff == ST_WAIT && nxt_st == ST_ACQ
    |-> period_end && dly_ff + 12'h001 >= cfg_if.trig_delay)
    else $error("acquisition began before delay");
  a_frame_end: assert property (
    st_ff == ST_ACQ && period_end && last_line
    |=> !frame_busy_o ##1 !bus_line_o)
    else $error("frame did not end after last line");
  a_retrig_ignored: assert property (
    st_ff == ST_ACQ && !period_end |=> st_ff == ST_ACQ)
    else $error("acquisition left early");
  a_scan_in_line: assert property (
    line_scan_o |-> bus_line_o && frame_busy_o)
    else $error("line scan outside a line");
  a_data_capture: assert property (
    st_ff == ST_ACQ && in_pix && slot_ff == 8'h00
    |=> bus_data_o == $past(adc_data_i) ##100 bus_clk_o)
    else $error("pixel word or bus clock wrong");
  a_clk_stable: assert property (
    $rose(bus_clk_o) |-> $stable(bus_data_o) && bus_line_o)
    else $error("data moved at bus clock edge");
  a_fault_or: assert property (
    |sync_ff[4:1] |=> bias_supply_fault_o)
    else $error("fault not reported");
  a_line_sweep: assert property (
    $rose(bus_line_o) |-> $past(pc_ff) == 20'h00000)
    else $error("line not aligned to sweep");

  c_frame_done: cover property (st_ff == ST_ACQ ##1 st_ff == ST_IDLE);
  c_hr_start: cover property (
    $rose(st_ff == ST_ACQ) && psq_is_hr(cfg_if.mode));
  c_retrig: cover property (st_ff == ST_ACQ && trig_sync);
  c_spi_hold: cover property (
    st_ff == ST_IDLE && trig_sync && cfg_if.spi_active);
endmodule // psq_plate_scan_sequencer
`default_nettype wire

// >>> psq_spi_slave.sv
// Serial slave port holding mode and trigger delay settings
`timescale 1ns/100ps
`default_nettype none
module psq_spi_slave (
  input wire logic clock_i,
  input wire logic sys_rst_i,
  input wire logic spi_sclk_i,
  input wire logic spi_mosi_i,
  input wire logic spi_ss_n_i,
  output logic spi_miso_o,
  output logic spi_miso_oe_n_o,
  psq_cfg_if.spi cfg
);
  import psq_pkg::*;
  logic [2:0] meta_ff, sync_ff, prev_ff;
  logic [15:0] rx_ff, nxt_rx, tx_ff, nxt_tx, rd_ff, nxt_rd;
  logic [4:0] cnt_ff, nxt_cnt;
  psq_mode_type mode_ff, nxt_mode;
  logic [11:0] dly_ff, nxt_dly;
  logic sclk_rise, sclk_fall, ss_fall, ss_rise, sel;

  // Two stages before any logic looks at the host pins; reset to the idle
  // levels (select high, clock low) so no false edge follows reset
  always_ff @(posedge clock_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      meta_ff <= 3'h4;
      sync_ff <= 3'h4;
      prev_ff <= 3'h4;
    end else begin
      meta_ff <= {spi_ss_n_i, spi_mosi_i, spi_sclk_i};
      sync_ff <= meta_ff;
      prev_ff <= sync_ff;
    end
  end

  // Clock edges count only while select is low
  assign sel = !sync_ff[2];
  assign sclk_rise = sel && sync_ff[0] && !prev_ff[0];
  assign sclk_fall = sel && !sync_ff[0] && prev_ff[0];
  assign ss_fall = !sync_ff[2] && prev_ff[2];
  assign ss_rise = sync_ff[2] && !prev_ff[2];

  // Shift in on rising clock, out on falling; decode when select ends
  always_comb begin
    nxt_rx = rx_ff;
    nxt_tx = tx_ff;
    nxt_rd = rd_ff;
    nxt_cnt = cnt_ff;
    nxt_mode = mode_ff;
    nxt_dly = dly_ff;
    if (ss_fall) begin
      nxt_tx = rd_ff; // Reply to the previous read frame
      nxt_cnt = 5'h00;
    end else if (sclk_rise) begin
      nxt_rx = {rx_ff[14:0], sync_ff[1]};
      nxt_cnt = cnt_ff + 5'h01;
    end else if (sclk_fall) begin
      nxt_tx = {tx_ff[14:0], 1'b0};
    end
    // Frames seen while busy are dropped; the host waits for permit
    if (ss_rise && cnt_ff == 5'(SPI_BITS) && !cfg.busy) begin
      if (rx_ff[15]) begin
        if (rx_ff[14:12] == ADDR_MODE)
          nxt_rd = {14'h0000, mode_ff};
        else if (rx_ff[14:12] == ADDR_DELAY)
          nxt_rd = {4'h0, dly_ff};
        else if (rx_ff[14:12] == ADDR_STATUS)
          nxt_rd = {14'h0000, cfg.fault, cfg.busy};
        else
          nxt_rd = 16'h0000;
      end else if (rx_ff[14:12] == ADDR_MODE) begin
        nxt_mode = psq_mode_type'(rx_ff[1:0]);
      end else if (rx_ff[14:12] == ADDR_DELAY) begin
        // Out of range delays are clamped to the legal span
        if (rx_ff[11:0] < DELAY_MIN)
          nxt_dly = DELAY_MIN;
        else if (rx_ff[11:0] > DELAY_MAX)
          nxt_dly = DELAY_MAX;
        else
          nxt_dly = rx_ff[11:0];
      end
    end
  end

  // Register the port state
  always_ff @(posedge clock_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      rx_ff <= 16'h0000;
      tx_ff <= 16'h0000;
      rd_ff <= 16'h0000;
      cnt_ff <= 5'h00;
      mode_ff <= MODE_RESET;
      dly_ff <= DELAY_RESET;
    end else begin
      rx_ff <= nxt_rx;
      tx_ff <= nxt_tx;
      rd_ff <= nxt_rd;
      cnt_ff <= nxt_cnt;
      mode_ff <= nxt_mode;
      dly_ff <= nxt_dly;
    end
  end

  assign spi_miso_o = tx_ff[15];
  assign spi_miso_oe_n_o = !sel;
  assign cfg.mode = mode_ff;
  assign cfg.trig_delay = dly_ff;
  assign cfg.spi_active = sel;

  default clocking cb @(posedge clock_i); endclocking
  default disable iff (sys_rst_i);
  a_delay_range: assert property (
    dly_ff >= DELAY_MIN && dly_ff <= DELAY_MAX)
    else $error("trigger delay out of range");
  a_miso_float: assert property (
    !sel |-> spi_miso_oe_n_o)
    else $error("miso driven while deselected");
endmodule // psq_spi_slave
`default_nettype wire

// >>> tb_top.sv
// Self-checking bench of the plate scan sequencer
`timescale 1ns/100ps
`default_nettype none
module tb_top;
  import psq_pkg::*;
  logic clock_i = 1'b0;
  logic sys_rst_i = 1'b1;
  logic trig = 1'b0;
  logic sclk, mosi, ss_n, miso, miso_oe_n;
  logic [15:0] adc = 16'h0000;
  logic [3:0] flt = 4'h0;
  logic busy, permit, lscan, bclk, bline, bfault, mdrive;
  logic [15:0] bdata;
  logic [15:0] r;
  // Short mirror period: a first line is reachable, a whole frame is not
  localparam int MIR_CYC = 500;
  int err_total = 0;
  int comparisons = 0;
  int n;
  int seed = 32'h43d4;
  int m_delay;
  int i;
  int dl[6];

  // 200 MHz system clock
  always #2.5 clock_i = ~clock_i;

  // Detector samples change at random every cycle
  always @(negedge clock_i) begin
    adc <= 16'($random(seed));
  end

  psq_plate_scan_sequencer #(
    .MIRROR_STD_CYC(MIR_CYC),
    .MIRROR_HR_CYC(MIR_CYC + 200)
  ) psq_plate_scan_sequencer_i (
    .clock_i(clock_i), .sys_rst_i(sys_rst_i),
    .sequence_trigger_in_i(trig), .spi_sclk_i(sclk),
    .spi_mosi_i(mosi), .spi_ss_n_i(ss_n), .spi_miso_o(miso),
    .spi_miso_oe_n_o(miso_oe_n), .adc_data_i(adc),
    .overcurrent_i(flt[0]), .temp_sensor_open_i(flt[1]),
    .temp_abnormal_i(flt[2]), .supply_unstable_i(flt[3]),
    .frame_busy_o(busy), .link_permit_o(permit), .line_scan_o(lscan),
    .bus_clk_o(bclk), .bus_line_o(bline), .bus_data_o(bdata),
    .bias_supply_fault_o(bfault), .mirror_drive_o(mdrive)
  );

  psq_host_model psq_host_model_i (
    .clock_i(clock_i), .link_permit_i(permit), .miso_i(miso),
    .miso_oe_n_i(miso_oe_n), .sclk_o(sclk), .mosi_o(mosi), .ss_n_o(ss_n)
  );

  task automatic check(input logic [15:0] got, input logic [15:0] exp,
                       input string msg);
    comparisons++;
    if (got !== exp) begin
      err_total++;
      $display("[FAIL] %0t %s got %h exp %h", $time, msg, got, exp);
    end
  endtask

  task automatic report_and_stop;
    if (err_total == 0 && comparisons > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  task automatic spi_write(input logic [2:0] a, input logic [11:0] d);
    logic [15:0] x;
    psq_host_model_i.xfer({1'b0, a, d}, 16, x);
  endtask

  // Read data comes back in the following frame, a harmless status read
  task automatic spi_read(input logic [2:0] a, output logic [15:0] d);
    logic [15:0] x;
    psq_host_model_i.xfer({1'b1, a, 12'h000}, 16, x);
    psq_host_model_i.xfer({1'b1, ADDR_STATUS, 12'h000}, 16, d);
  endtask

  // Bench model of the delay setting: held within 100 to 4000
  function automatic int clamp_delay(input int v);
    if (v < 100) begin
      return 100;
    end
    return (v > 4000) ? 4000 : v;
  endfunction

  task automatic apply_faults(input logic [3:0] f);
    flt = f;
    repeat (6) @(negedge clock_i);
    check({15'h0000, bfault}, {15'h0000, |f}, "fault level");
  endtask

  // Watchdog: the tests take about 65k cycles, the limit is 90k
  initial begin
    #450000;
    err_total++;
    report_and_stop;
  end

  initial begin
    repeat (20) @(negedge clock_i);
    sys_rst_i = 1'b0;
    check({10'h000, busy, permit, lscan, bline, bclk, miso_oe_n},
          16'h0011, "reset levels");
    for (i = 0; i < 16; i++) begin
      apply_faults(i[3:0]);
    end
    for (i = 0; i < 4; i++) begin
      spi_write(ADDR_MODE, 12'(i));
      spi_read(ADDR_MODE, r);
      check(r, 16'(i), "mode readback");
    end
    dl = '{50, 100, 4000, 4095, 1, 100 + ($unsigned($random(seed)) % 3901)};
    for (i = 0; i < 6; i++) begin
      spi_write(ADDR_DELAY, 12'(dl[i]));
      m_delay = clamp_delay(dl[i]);
      spi_read(ADDR_DELAY, r);
      check(r, 16'(m_delay), "delay readback");
    end
    // A frame one bit short must leave the setting alone
    psq_host_model_i.xfer({1'b0, ADDR_DELAY, 12'h200}, 15, r);
    spi_read(ADDR_DELAY, r);
    check(r, 16'(m_delay), "short frame");
    spi_read(3'h5, r);
    check(r, 16'h0000, "unmapped read");
    flt = 4'h4;
    repeat (6) @(negedge clock_i);
    spi_read(ADDR_STATUS, r);
    check(r, 16'h0002, "status read");
    flt = 4'h0;
    spi_write(ADDR_MODE, 12'h000);
    spi_write(ADDR_DELAY, 12'h064);
    trig = 1'b1;
    repeat (6) @(negedge clock_i);
    check({15'h0000, busy}, 16'h0001, "busy after trigger");
    check({15'h0000, permit}, 16'h0000, "permit while busy");
    for (i = 0; i < 2000; i++) begin
      @(negedge clock_i);
      check({14'h0000, lscan, bline}, 16'h0000, "line in delay");
    end
    trig = 1'b0;
    repeat (10) @(negedge clock_i);
    trig = 1'b1;
    repeat (10) @(negedge clock_i);
    check({15'h0000, busy}, 16'h0001, "retrigger");
    // First line opens on a sweep start 99 to 100 periods after trigger;
    // trigger stays high throughout and must be ignored
    n = 2026;
    while (bline !== 1'b1 && n < 100 * MIR_CYC + 10) begin
      @(negedge clock_i);
      n++;
    end
    comparisons++;
    if (n < 99 * MIR_CYC + 4 || n > 100 * MIR_CYC + 5) begin
      err_total++;
      $display("[FAIL] %0t first line after %0d cycles", $time, n);
    end
    check({15'h0000, mdrive}, 16'h0001, "mirror first half");
    repeat (199) @(negedge clock_i);
    check({14'h0000, lscan, bline}, 16'h0001, "lead before pixels");
    @(negedge clock_i);
    check({14'h0000, lscan, busy}, 16'h0003, "pixels open");
    r = adc;
    check(bdata, r, "first pixel word");
    repeat (99) @(negedge clock_i);
    check({15'h0000, bclk}, 16'h0000, "bus clock low half");
    @(negedge clock_i);
    check({14'h0000, bclk, mdrive}, 16'h0002, "bus clock high");
    check(bdata, r, "pixel word held");
    check({15'h0000, busy}, 16'h0001, "retrigger in line");
    trig = 1'b0;
    sys_rst_i = 1'b1;
    repeat (3) @(negedge clock_i);
    check({14'h0000, busy, permit}, 16'h0001, "mid reset");
    sys_rst_i = 1'b0;
    repeat (5) @(negedge clock_i);
    spi_read(ADDR_DELAY, r);
    check(r, {4'h0, DELAY_RESET}, "delay after reset");
    report_and_stop;
  end
endmodule // tb_top
`default_nettype wire
